// file: hw/periodic_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - ten-bit up counter, selectable clock source
// - comparators A and P watch the counter
// - timer-on rise clears counter; fall holds it
// - overflow or selected match clears, raises flag
// - pause bit freezes counter, clear resumes
// - three-bit field picks counter clock
// - timer-on enables counting; off stops it
// - compare mode: timer-on rise restores initial pin
// - two-bit mode field selects operating mode
// - timer/counter mode leaves pins undriven
// - compare mode: A match keeps/low/high/toggle
// - pwm mode: inactive, active, pwm, pulse
// - capture mode: rise, fall, both, none
// - no pin change when level already matches
// - output control: initial or active level
// - invert bit flips pin, ignored in timer mode
// - capture source: pins or external clock pin
// - clear on A match, else P/overflow
// - clear select ignored in pwm/pulse/capture
// - counter read only, compares read/write, zeros
// - compare A direct when off, else at reload
// - pwm period P clocks, zero gives 1024
module periodic_timer (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, low
  input wire logic pclk_en, // clock enable, freezes all state
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic external_clock_pin, // external clock and trigger
  input wire logic timebase_clock, // timebase clock
  input wire logic timer_pin_0_in, // pin 0 level
  output logic timer_pin_0_out, // pin 0 drive level
  output logic timer_pin_0_oe, // pin 0 driven
  input wire logic timer_pin_1_in, // pin 1 level
  output logic timer_pin_1_out, // pin 1 drive level
  output logic timer_pin_1_oe // pin 1 driven
);
  ptm_tick_if tk ();

  logic [7:0] ctrl0_q, ctrl1_q;
  logic [9:0] count_q, cmp_a_buf_q, cmp_a_q, cmp_p_q;
  logic a_flag_q, p_flag_q, adjust_q, on_prev_q, pending_q;
  logic out_q, pin_q, ack_q, err_q;
  logic [31:0] rdata_q;
  logic [2:0] clock_select;
  logic count_pause, timer_on, output_control, output_invert;
  logic capture_source_select, clear_select;
  logic [1:0] mode_select, pin_function_select;
  logic on_rise, run, tick_run, a_hit, p_end, p_hit, cnt_clear;
  logic single, cap_event, set_a, set_p, hw_on_set, hw_on_clr;
  logic [9:0] cnt_inc;
  logic wr, mapped, drive, level_active, pin_level;
  logic [1:0] edge_rise, edge_fall;
  logic [7:0] wbyte;

  // ****************************************************************
  // clock source and pin synchronisers
  // ****************************************************************
  ptm_clock_gen u_clock_gen (
    .pclk(pclk),
    .presetn(presetn),
    .pclk_en(pclk_en),
    .pins_raw({timer_pin_1_in, timer_pin_0_in, timebase_clock,
               external_clock_pin}),
    .tk(tk)
  );

  // ****************************************************************
  // control fields
  // ****************************************************************
  assign count_pause = ctrl0_q[ptm_pkg::pause_bit];
  assign clock_select = ctrl0_q[ptm_pkg::clksel_lsb +: 3];
  assign timer_on = ctrl0_q[ptm_pkg::on_bit];
  assign mode_select = ctrl1_q[ptm_pkg::mode_lsb +: 2];
  assign pin_function_select = ctrl1_q[ptm_pkg::pinfn_lsb +: 2];
  assign output_control = ctrl1_q[ptm_pkg::oc_bit];
  assign output_invert = ctrl1_q[ptm_pkg::inv_bit];
  assign capture_source_select = ctrl1_q[ptm_pkg::capsrc_bit];
  assign clear_select = ctrl1_q[ptm_pkg::clrsel_bit];
  assign tk.clock_select = clock_select;
  assign single = (mode_select == ptm_pkg::mode_pwm) &&
                  (pin_function_select == ptm_pkg::fn_3);
  assign wbyte = pwdata[7:0];

  // ****************************************************************
  // counting and comparators
  // ****************************************************************
  assign on_rise = timer_on & ~on_prev_q;
  assign run = timer_on & ~count_pause;
  assign tick_run = tk.tick & run;
  assign cnt_inc = count_q + 10'h001;
  assign a_hit = tick_run && (cnt_inc == cmp_a_q);
  assign p_end = (cmp_p_q == ptm_pkg::value_rst) ?
                 (count_q == ptm_pkg::count_max) : (cnt_inc == cmp_p_q);
  assign p_hit = tick_run & p_end;

  // clear source per mode; single pulse only restarts on timer-on
  always_comb begin
    case (mode_select)
      ptm_pkg::mode_compare,
      ptm_pkg::mode_timer: cnt_clear = clear_select ? a_hit : p_hit;
      ptm_pkg::mode_pwm: cnt_clear = single ? 1'b0 : p_hit;
      ptm_pkg::mode_capture: cnt_clear = p_hit;
      default: cnt_clear = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= ptm_pkg::value_rst;
      on_prev_q <= 1'b0;
    end else if (pclk_en) begin
      on_prev_q <= timer_on;
      if (on_rise) begin
        count_q <= ptm_pkg::value_rst;
      end else if (cnt_clear) begin
        count_q <= ptm_pkg::value_rst;
      end else if (tick_run) begin
        count_q <= cnt_inc;
      end
    end
  end

  // ****************************************************************
  // capture
  // ****************************************************************
  // capture source
  assign edge_rise = capture_source_select ? {1'b0, tk.ext_rise} :
                     tk.cap_rise;
  assign edge_fall = capture_source_select ? {1'b0, tk.ext_fall} :
                     tk.cap_fall;

  always_comb begin
    case (pin_function_select)
      ptm_pkg::fn_0: cap_event = |edge_rise;
      ptm_pkg::fn_1: cap_event = |edge_fall;
      ptm_pkg::fn_2: cap_event = |(edge_rise | edge_fall);
      ptm_pkg::fn_3: cap_event = 1'b0;
      default: cap_event = 1'b0;
    endcase
    if (!(timer_on && mode_select == ptm_pkg::mode_capture)) begin
      cap_event = 1'b0;
    end
  end

  // ****************************************************************
  // match flags
  // ****************************************************************
  always_comb begin
    case (mode_select)
      ptm_pkg::mode_capture: begin
        set_a = cap_event;
        set_p = p_hit;
      end
      ptm_pkg::mode_pwm: begin
        set_a = a_hit;
        set_p = single ? 1'b0 : p_hit;
      end
      default: begin
        set_a = a_hit;
        set_p = ~clear_select & p_hit;
      end
    endcase
  end

  // sticky flags
  // write one to clear; a hit in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_flag_q <= 1'b0;
      p_flag_q <= 1'b0;
    end else if (pclk_en) begin
      if (set_a) begin
        a_flag_q <= 1'b1;
      end else if (wr && paddr == ptm_pkg::flags_off &&
                   wbyte[ptm_pkg::flag_a_bit]) begin
        a_flag_q <= 1'b0;
      end
      if (set_p) begin
        p_flag_q <= 1'b1;
      end else if (wr && paddr == ptm_pkg::flags_off &&
                   wbyte[ptm_pkg::flag_p_bit]) begin
        p_flag_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  // single pulse: external rise starts, A match ends the pulse
  assign hw_on_set = single & ~timer_on & tk.ext_rise;
  assign hw_on_clr = single & a_hit;

  // hardware start beats a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_q <= ptm_pkg::ctrl_rst;
    end else if (pclk_en) begin
      if (wr && paddr == ptm_pkg::ctrl0_off) begin
        ctrl0_q <= {wbyte[7:3], 3'h0};
      end
      if (hw_on_set) begin
        ctrl0_q[ptm_pkg::on_bit] <= 1'b1;
      end else if (hw_on_clr) begin
        ctrl0_q[ptm_pkg::on_bit] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_q <= ptm_pkg::ctrl_rst;
      adjust_q <= 1'b0;
    end else if (pclk_en) begin
      if (wr && paddr == ptm_pkg::ctrl1_off) begin
        ctrl1_q <= wbyte;
      end
      if (wr && paddr == ptm_pkg::adjust_off) begin
        adjust_q <= wbyte[ptm_pkg::adjust_bit];
      end
    end
  end

  // ****************************************************************
  // compare values
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_p_q <= ptm_pkg::value_rst;
    end else if (pclk_en) begin
      if (wr && paddr == ptm_pkg::cmpp_lo_off) begin
        cmp_p_q[7:0] <= wbyte;
      end
      if (wr && paddr == ptm_pkg::cmpp_hi_off) begin
        cmp_p_q[9:8] <= wbyte[1:0];
      end
    end
  end

  // compare A reload
  // a running timer only picks up a new A at the next counter clear,
  // so a half-written pair never reaches the comparator mid-period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_a_buf_q <= ptm_pkg::value_rst;
      cmp_a_q <= ptm_pkg::value_rst;
      pending_q <= 1'b0;
    end else if (pclk_en) begin
      if (cap_event) begin
        cmp_a_buf_q <= count_q;
        cmp_a_q <= count_q;
        pending_q <= 1'b0;
      end else if (wr && !adjust_q && (paddr == ptm_pkg::cmpa_lo_off ||
                                       paddr == ptm_pkg::cmpa_hi_off)) begin
        if (paddr == ptm_pkg::cmpa_lo_off) begin
          cmp_a_buf_q[7:0] <= wbyte;
        end else begin
          cmp_a_buf_q[9:8] <= wbyte[1:0];
        end
        if (!timer_on) begin
          if (paddr == ptm_pkg::cmpa_lo_off) begin
            cmp_a_q[7:0] <= wbyte;
          end else begin
            cmp_a_q[9:8] <= wbyte[1:0];
          end
        end else begin
          pending_q <= 1'b1;
        end
      end else if (pending_q && (cnt_clear || on_rise ||
                   (tick_run && count_q == ptm_pkg::count_max))) begin
        cmp_a_q <= cmp_a_buf_q;
        pending_q <= 1'b0;
      end else if (pending_q && !timer_on) begin
        cmp_a_q <= cmp_a_buf_q;
        pending_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // output pins
  // ****************************************************************
  // compare mode level, set on timer-on rise and moved by A matches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 1'b0;
    end else if (pclk_en && mode_select == ptm_pkg::mode_compare) begin
      if (on_rise) begin
        out_q <= output_control;
      end else if (a_hit) begin
        case (pin_function_select)
          ptm_pkg::fn_0: out_q <= out_q;
          ptm_pkg::fn_1: out_q <= 1'b0;
          ptm_pkg::fn_2: out_q <= 1'b1;
          ptm_pkg::fn_3: out_q <= ~out_q;
          default: out_q <= out_q;
        endcase
      end
    end
  end

  // pwm pin function
  // pwm compare runs even while forced; duty at or over period is 100%
  always_comb begin
    case (pin_function_select)
      ptm_pkg::fn_0: level_active = 1'b0;
      ptm_pkg::fn_1: level_active = 1'b1;
      ptm_pkg::fn_2: level_active = timer_on && (count_q < cmp_a_q);
      ptm_pkg::fn_3: level_active = timer_on;
      default: level_active = 1'b0;
    endcase
  end

  assign drive = (mode_select == ptm_pkg::mode_compare) ||
                 (mode_select == ptm_pkg::mode_pwm);

  always_comb begin
    if (mode_select == ptm_pkg::mode_compare) begin
      pin_level = out_q;
    end else begin
      pin_level = level_active ? output_control : ~output_control;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'b0;
    end else if (pclk_en) begin
      pin_q <= drive ? (pin_level ^ output_invert) : 1'b0;
    end
  end

  assign timer_pin_0_out = pin_q;
  assign timer_pin_1_out = pin_q;
  assign timer_pin_0_oe = drive;
  assign timer_pin_1_oe = drive;

  // ****************************************************************
  // apb slave
  // ****************************************************************
  // one wait state: read data is sampled in the first access cycle, writes land in the second
  assign wr = psel & penable & pwrite & ack_q & pclk_en;

  always_comb begin
    case (paddr)
      ptm_pkg::ctrl0_off, ptm_pkg::ctrl1_off, ptm_pkg::cnt_lo_off,
      ptm_pkg::cnt_hi_off, ptm_pkg::cmpa_lo_off, ptm_pkg::cmpa_hi_off,
      ptm_pkg::cmpp_lo_off, ptm_pkg::cmpp_hi_off, ptm_pkg::flags_off,
      ptm_pkg::adjust_off: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
      ack_q <= 1'b0;
      err_q <= 1'b0;
    end else if (pclk_en) begin
      ack_q <= psel & penable & ~ack_q;
      err_q <= psel & penable & ~ack_q & ~mapped;
      rdata_q <= 32'h0000_0000;
      if (psel && penable && !ack_q && !pwrite) begin
        case (paddr)
          ptm_pkg::ctrl0_off: rdata_q[7:0] <= ctrl0_q;
          ptm_pkg::ctrl1_off: rdata_q[7:0] <= ctrl1_q;
          ptm_pkg::cnt_lo_off: rdata_q[7:0] <= count_q[7:0];
          ptm_pkg::cnt_hi_off: rdata_q[1:0] <= count_q[9:8];
          ptm_pkg::cmpa_lo_off: rdata_q[7:0] <= cmp_a_buf_q[7:0];
          ptm_pkg::cmpa_hi_off: rdata_q[1:0] <= cmp_a_buf_q[9:8];
          ptm_pkg::cmpp_lo_off: rdata_q[7:0] <= cmp_p_q[7:0];
          ptm_pkg::cmpp_hi_off: rdata_q[1:0] <= cmp_p_q[9:8];
          ptm_pkg::flags_off: rdata_q[1:0] <= {p_flag_q, a_flag_q};
          ptm_pkg::adjust_off: rdata_q[0] <= adjust_q;
          default: rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata = rdata_q;
  assign pready = ack_q & pclk_en;
  assign pslverr = err_q & pclk_en;
endmodule
`default_nettype wire

// file: hw/ptm_clock_gen.sv
`timescale 1ns/1ps
`default_nettype none
module ptm_clock_gen (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, low
  input wire logic pclk_en, // freezes state while low
  input wire logic [3:0] pins_raw, // ext, timebase, pin0, pin1
  ptm_tick_if.src tk // ticks and edges to the timer
);
  logic [3:0] s1_q, s2_q, s3_q, lvl_q, stable, rise, fall;
  logic [5:0] div_q;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // three stages; a level counts once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q[i] <= 1'b0;
          s2_q[i] <= 1'b0;
          s3_q[i] <= 1'b0;
          lvl_q[i] <= 1'b0;
        end else if (pclk_en) begin
          s1_q[i] <= pins_raw[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (stable[i]) begin
            lvl_q[i] <= s3_q[i];
          end
        end
      end
      assign stable[i] = s2_q[i] == s3_q[i];
      assign rise[i] = stable[i] & s3_q[i] & ~lvl_q[i];
      assign fall[i] = stable[i] & ~s3_q[i] & lvl_q[i];
    end
  endgenerate

  // ****************************************************************
  // prescaler
  // ****************************************************************
  // free running, so the first divided tick after a switch can land mid-way
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 6'h00;
    end else if (pclk_en) begin
      div_q <= div_q + 6'h01;
    end
  end

  // fH taken as the system clock itself
  always_comb begin
    case (tk.clock_select)
      ptm_pkg::ck_sys_div4: tk.tick = div_q[1:0] == ptm_pkg::div4_last[1:0];
      ptm_pkg::ck_sys: tk.tick = 1'b1;
      ptm_pkg::ck_h_div16: tk.tick = div_q[3:0] == ptm_pkg::div16_last[3:0];
      ptm_pkg::ck_h_div64: tk.tick = div_q == ptm_pkg::div64_last;
      ptm_pkg::ck_timebase: tk.tick = rise[1];
      ptm_pkg::ck_h: tk.tick = 1'b1;
      ptm_pkg::ck_ext_rise: tk.tick = rise[0];
      ptm_pkg::ck_ext_fall: tk.tick = fall[0];
      default: tk.tick = 1'b0;
    endcase
  end

  assign tk.ext_rise = rise[0];
  assign tk.ext_fall = fall[0];
  assign tk.cap_rise = rise[3:2];
  assign tk.cap_fall = fall[3:2];
endmodule
`default_nettype wire

// file: pkg/ptm_pkg.sv
package ptm_pkg;
  // ****************************************************************
  // register map (byte addresses on the apb bus)
  // ****************************************************************
  localparam logic [7:0] ctrl0_off = 8'h00;
  localparam logic [7:0] ctrl1_off = 8'h04;
  localparam logic [7:0] cnt_lo_off = 8'h08;
  localparam logic [7:0] cnt_hi_off = 8'h0c;
  localparam logic [7:0] cmpa_lo_off = 8'h10;
  localparam logic [7:0] cmpa_hi_off = 8'h14;
  localparam logic [7:0] cmpp_lo_off = 8'h18;
  localparam logic [7:0] cmpp_hi_off = 8'h1c;
  localparam logic [7:0] flags_off = 8'h20;
  localparam logic [7:0] adjust_off = 8'h24;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] ctrl_rst = 8'h00;
  localparam logic [9:0] value_rst = 10'h000;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int pause_bit = 7;
  localparam int clksel_lsb = 4;
  localparam int on_bit = 3;
  localparam int mode_lsb = 6;
  localparam int pinfn_lsb = 4;
  localparam int oc_bit = 3;
  localparam int inv_bit = 2;
  localparam int capsrc_bit = 1;
  localparam int clrsel_bit = 0;
  localparam int flag_a_bit = 0;
  localparam int flag_p_bit = 1;
  localparam int adjust_bit = 0;

  // ****************************************************************
  // encodings
  // ****************************************************************
  localparam logic [1:0] mode_compare = 2'h0;
  localparam logic [1:0] mode_capture = 2'h1;
  localparam logic [1:0] mode_pwm = 2'h2;
  localparam logic [1:0] mode_timer = 2'h3;
  localparam logic [1:0] fn_0 = 2'h0;
  localparam logic [1:0] fn_1 = 2'h1;
  localparam logic [1:0] fn_2 = 2'h2;
  localparam logic [1:0] fn_3 = 2'h3;
  localparam logic [2:0] ck_sys_div4 = 3'h0;
  localparam logic [2:0] ck_sys = 3'h1;
  localparam logic [2:0] ck_h_div16 = 3'h2;
  localparam logic [2:0] ck_h_div64 = 3'h3;
  localparam logic [2:0] ck_timebase = 3'h4;
  localparam logic [2:0] ck_h = 3'h5;
  localparam logic [2:0] ck_ext_rise = 3'h6;
  localparam logic [2:0] ck_ext_fall = 3'h7;

  // ****************************************************************
  // cycle counts
  // ****************************************************************
  localparam logic [5:0] div4_last = 6'h03;
  localparam logic [5:0] div16_last = 6'h0f;
  localparam logic [5:0] div64_last = 6'h3f;
  localparam logic [9:0] count_max = 10'h3ff;
endpackage

// file: pkg/ptm_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// counter clock and synchronised pin events
// ****************************************************************
interface ptm_tick_if;
  logic [2:0] clock_select;
  logic tick;
  logic ext_rise;
  logic ext_fall;
  logic [1:0] cap_rise;
  logic [1:0] cap_fall;
  modport src (input clock_select, output tick, ext_rise, ext_fall,
               cap_rise, cap_fall);
  modport snk (output clock_select, input tick, ext_rise, ext_fall,
               cap_rise, cap_fall);
endinterface
`default_nettype wire

// file: verif/periodic_timer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// bus and pin checks
// ****************
module periodic_timer_assertions (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, low
  input wire logic pclk_en, // enable
  input wire logic psel, // select
  input wire logic penable, // access
  input wire logic pwrite, // write
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic timer_pin_0_out, // pin 0
  input wire logic timer_pin_1_out, // pin 1
  input wire logic timer_pin_0_oe, // pin 0 drive
  input wire logic timer_pin_1_oe // pin 1 drive
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // setup then access, answer one cycle later
  sequence s_setup; psel && !penable && pclk_en; endsequence
  sequence s_access; psel && penable && pclk_en; endsequence
  property p_wait; s_setup ##1 s_access |-> !pready ##1 pready; endproperty
  a_wait: assert property (p_wait) else $error("ready late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held");
  property p_req; pready |-> psel && penable && pclk_en; endproperty
  a_req: assert property (p_req) else $error("stray ready");
  // error only beyond the last mapped word
  property p_map;
    pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h24);
  endproperty
  a_map: assert property (p_map) else $error("bad error");
  property p_ezero; pready && pslverr && !pwrite |-> prdata == 0; endproperty
  a_ezero: assert property (p_ezero) else $error("error data");
  // unimplemented bits read zero
  property p_hi;
    pready && !pwrite && paddr inside {8'h0c, 8'h14, 8'h1c}
      |-> prdata[31:2] == 30'h0;
  endproperty
  a_hi: assert property (p_hi) else $error("high bits set");
  property p_c0; pready && !pwrite && paddr == 8'h00 |-> prdata[2:0] == 0;
  endproperty
  a_c0: assert property (p_c0) else $error("ctrl0 low bits");
  // both pins carry one function
  property p_pins; timer_pin_0_out == timer_pin_1_out; endproperty
  a_pins: assert property (p_pins) else $error("pins differ");
  property p_oe; timer_pin_0_oe == timer_pin_1_oe; endproperty
  a_oe: assert property (p_oe) else $error("enables differ");
endmodule
bind periodic_timer periodic_timer_assertions chk_u (
  .pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .timer_pin_0_out(timer_pin_0_out),
  .timer_pin_1_out(timer_pin_1_out), .timer_pin_0_oe(timer_pin_0_oe),
  .timer_pin_1_oe(timer_pin_1_oe));
`default_nettype wire

// file: verif/periodic_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// register level bench
// ****************
module periodic_timer_tb;
  logic pclk, presetn, psel, penable, pwrite, pslverr, pready, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, v;
  logic p0_out, p0_oe, p1_out, p1_oe;
  logic ext, tp0;
  logic [2:0] m;
  int failures, total_checks;
  // 100 mhz clock
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;
  // timebase and pin 1 idle; ext and pin 0 feed the capture tests
  periodic_timer dut_u (.pclk(pclk), .presetn(presetn), .pclk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_clock_pin(ext), .timebase_clock(1'b0),
    .timer_pin_0_in(tp0), .timer_pin_0_out(p0_out),
    .timer_pin_0_oe(p0_oe), .timer_pin_1_in(1'b0),
    .timer_pin_1_out(p1_out), .timer_pin_1_oe(p1_oe));
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task check(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, g, x);
    end
  endtask
  // one apb transfer, request held until ready
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a hung wait
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 8'h00);
    check(r, x);
  endtask
  // counter must stay below the clearing value
  task span(input logic [31:0] lim);
    repeat (3) begin
      apb(1'b0, 8'h08, 8'h00);
      check({31'h0, r < lim}, 32'h1);
    end
  endtask
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext = 1'b0;
    tp0 = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(8'(i * 4), 32'h0);
    wr(8'h00, 8'h07);
    rd(8'h00, 32'h0);
    wr(8'h1c, 8'hff);
    rd(8'h1c, 32'h3);
    wr(8'h08, 8'h55);
    rd(8'h08, 32'h0);
    rd(8'h40, 32'h0);
    check({31'h0, e}, 32'h1);
    $display("test registers done");
    wr(8'h1c, 8'h00);
    wr(8'h18, 8'h05);
    wr(8'h04, 8'hc0);
    wr(8'h00, 8'h98);
    rd(8'h08, 32'h0);
    rd(8'h08, 32'h0);
    wr(8'h00, 8'h18);
    span(32'h5);
    rd(8'h20, 32'h2);
    wr(8'h00, 8'h98);
    wr(8'h20, 8'h03);
    rd(8'h20, 32'h0);
    apb(1'b0, 8'h08, 8'h00);
    v = r;
    rd(8'h08, v);
    wr(8'h00, 8'h00);
    rd(8'h08, v);
    wr(8'h10, 8'h03);
    wr(8'h04, 8'hc1);
    wr(8'h00, 8'h18);
    span(32'h3);
    $display("test counter done");
    wr(8'h18, 8'h00);
    // timer stopped before every mode change
    for (int k = 0; k < 8; k++) begin
      m = 3'(k);
      wr(8'h00, 8'h00);
      wr(8'h04, {2'h0, m, 3'h0});
      wr(8'h00, 8'h98);
      // level register, then pin register: two edges after the write
      repeat (3) @(posedge pclk);
      check({31'h0, p0_out}, {31'h0, m[0]});
      rd(8'h08, 32'h0);
      wr(8'h00, 8'h18);
      repeat (20) @(posedge pclk);
      v = (m[2:1] == 2'h0) ? m[0] : (m[2:1] == 2'h3) ? !m[0] : m[2];
      check({31'h0, p0_out}, v);
      check({31'h0, p0_oe}, 32'h1);
    end
    for (int k = 0; k < 4; k++) begin
      m = 3'(k);
      wr(8'h00, 8'h00);
      wr(8'h04, {3'h4, m[0], 1'b1, m[1], 2'h0});
      wr(8'h00, 8'h18);
      repeat (2) @(posedge pclk);
      check({31'h0, p0_out}, {31'h0, m[0] ^ m[1]});
    end
    wr(8'h00, 8'h00);
    wr(8'h04, 8'hc0);
    repeat (2) @(posedge pclk);
    check({31'h0, p0_oe}, 32'h0);
    $display("test pins done");
    // adjust switch high: compare a writes refused
    wr(8'h24, 8'h01);
    wr(8'h10, 8'h77);
    rd(8'h10, 32'h3);
    wr(8'h24, 8'h00);
    // capture on a rising edge of pin 0
    wr(8'h04, 8'h40);
    wr(8'h20, 8'h03);
    wr(8'h00, 8'h18);
    tp0 <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(8'h20, 32'h1);
    // both edges, taken from the external pin only
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h62);
    wr(8'h20, 8'h03);
    wr(8'h00, 8'h18);
    tp0 <= 1'b0;
    repeat (8) @(posedge pclk);
    rd(8'h20, 32'h0);
    ext <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(8'h20, 32'h1);
    wr(8'h00, 8'h00);
    $display("test capture done");
    end_of_test;
  end
  // hang guard, far beyond the expected few hundred cycles
  initial begin
    #200000;
    failures++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test;
  end
endmodule
`default_nettype wire
